/* File: logic/nrc_host.sv */
`timescale 1ns/10ps
module nrc_host (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [11:0] req_column,
  input wire logic [15:0] req_row,
  input wire logic req_id_standard,
  input wire logic req_allow_write,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_done,
  output logic [7:0] io_out,
  output logic io_oe_n,
  input wire logic [7:0] io_in,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic command_latch_strobe,
  output logic address_latch_strobe,
  output logic write_guard_n,
  input wire logic ready_busy_n,
  output logic ready_busy_n_oe_n
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CMD1 = 4'b0001,
    S_ADDR = 4'b0010,
    S_CMD2 = 4'b0011,
    S_SETTLE = 4'b0100,
    S_WAIT_RDY = 4'b0101,
    S_READ = 4'b0110,
    S_DONE = 4'b0111
  } nrc_st_e;
  nrc_st_e st;
  nrc_cycle_if cyc ();
  logic [2:0] op;
  logic [11:0] column;
  logic [15:0] row;
  logic id_std;
  logic allow_write;
  logic [2:0] addr_idx;
  logic [5:0] settle;
  logic issued;
  logic [11:0] bytes_left;
  logic [2:0] rb_sync;
  logic rb_level;
  logic [11:0] remaining;
  // ready_busy_n from a pin: three flops, second and third agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rb_sync <= 3'h0;
      rb_level <= 1'b0;
    end else begin
      rb_sync <= {rb_sync[1:0], ready_busy_n};
      if (rb_sync[1] == rb_sync[2]) begin
        rb_level <= rb_sync[2];
      end
    end
  end
  // op decode
  wire op_page = (op == nrc_pkg::OP_PAGE_READ);
  wire op_first = (op == nrc_pkg::OP_FIRST_READ);
  wire op_rand = (op == nrc_pkg::OP_RANDOM_OUT);
  wire op_id = (op == nrc_pkg::OP_IDENT);
  wire op_param = (op == nrc_pkg::OP_PARAM);
  wire op_cbr = (op == nrc_pkg::OP_COPYBACK_READ);
  wire op_cbp = (op == nrc_pkg::OP_COPYBACK_PROG);
  wire op_bytes = (op == nrc_pkg::OP_READ_BYTES);
  // only defined codes are ever chosen
  wire [7:0] first_cmd =
    op_rand ? nrc_pkg::CMD_RANDOM_OUT :
    op_id ? nrc_pkg::CMD_IDENT :
    op_param ? nrc_pkg::CMD_PARAM_PAGE :
    op_cbp ? nrc_pkg::CMD_COPYBACK_PROG :
    nrc_pkg::CMD_READ_SETUP;
  wire [7:0] second_cmd =
    op_rand ? nrc_pkg::CMD_RANDOM_OUT_CONFIRM :
    op_cbr ? nrc_pkg::CMD_COPYBACK_READ :
    op_cbp ? nrc_pkg::CMD_PROG_CONFIRM :
    nrc_pkg::CMD_READ_CONFIRM;
  wire has_cmd1 = !op_first && !op_bytes;
  wire has_cmd2 = op_page || op_first || op_rand || op_cbr || op_cbp;
  wire [2:0] addr_count =
    (op_id || op_param) ? 3'h1 :
    op_rand ? 3'h2 :
    op_bytes ? 3'h0 : 3'h4;
  wire [7:0] id_addr =
    id_std ? nrc_pkg::ID_ADDR_STANDARD :
    nrc_pkg::ID_ADDR_DEVICE;
  wire [7:0] col_hi = {4'h0, column[11:8]};
  wire [7:0] addr_byte =
    (op_id || op_param) ? id_addr :
    (addr_idx == 3'h0) ? column[7:0] :
    (addr_idx == 3'h1) ? col_hi :
    (addr_idx == 3'h2) ? row[7:0] :
    row[15:8];
  // page read, first read, copyback read, parameter page and copyback program raise busy
  wire needs_wait = op_page || op_first || op_cbr || op_param || op_cbp;
  wire streams = (op_id || op_param || op_rand || op_page || op_first ||
    op_bytes) && (bytes_left != 12'h000);
  wire cyc_done = cyc.done;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= S_IDLE;
      op <= 3'h0;
      column <= 12'h000;
      row <= 16'h0000;
      id_std <= 1'b0;
      allow_write <= 1'b0;
      bytes_left <= 12'h000;
    end else begin
      unique case (st)
        S_IDLE: begin
          if (req_valid) begin
            op <= req_op;
            column <= req_column;
            row <= req_row;
            id_std <= req_id_standard;
            allow_write <= req_allow_write;
            bytes_left <= req_column;
            st <= S_CMD1;
          end
        end
        S_CMD1: begin
          if (!has_cmd1 || cyc_done) begin
            st <= (addr_count == 3'h0) ? S_READ : S_ADDR;
          end
        end
        S_ADDR: begin
          if (cyc_done && addr_idx == addr_count - 3'h1) begin
            st <= has_cmd2 ? S_CMD2 : (needs_wait ? S_SETTLE : S_READ);
          end
        end
        S_CMD2: begin
          if (cyc_done) begin
            st <= needs_wait ? S_SETTLE : S_READ;
          end
        end
        S_SETTLE: begin
          if (settle == nrc_pkg::BUSY_SETTLE_CNT) begin
            st <= S_WAIT_RDY;
          end
        end
        S_WAIT_RDY: begin
          if (rb_level) begin
            st <= S_READ;
          end
        end
        S_READ: begin
          if (!streams || (cyc_done && remaining == 12'h001)) begin
            st <= S_DONE;
          end
        end
        S_DONE: st <= S_IDLE;
        default: st <= S_IDLE;
      endcase
    end
  end
  // address index, settle timer, cycle launch, byte count
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_idx <= 3'h0;
      settle <= 6'h00;
      issued <= 1'b0;
      remaining <= 12'h000;
    end else begin
      if (st != S_ADDR) begin
        addr_idx <= 3'h0;
      end else if (cyc_done) begin
        addr_idx <= addr_idx + 3'h1;
      end
      settle <= (st == S_SETTLE) ? settle + 6'h01 : 6'h00;
      if (cyc_done || st == S_IDLE) begin
        issued <= 1'b0;
      end else if (cyc.start) begin
        issued <= 1'b1;
      end
      if (st != S_READ) begin
        remaining <= bytes_left;
      end else if (cyc_done) begin
        remaining <= remaining - 12'h001;
      end
    end
  end
  wire want_cycle = (st == S_CMD1 && has_cmd1) || (st == S_ADDR) ||
    (st == S_CMD2) || (st == S_READ && streams);
  assign cyc.start = want_cycle && !issued && !cyc_done;
  assign cyc.is_read = (st == S_READ);
  assign cyc.cmd_latch = (st == S_CMD1) || (st == S_CMD2);
  assign cyc.addr_latch = (st == S_ADDR);
  assign cyc.wdata = (st == S_CMD1) ? first_cmd :
    (st == S_CMD2) ? second_cmd : addr_byte;
  // read data and status outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      op_done <= 1'b0;
      chip_select_n <= 1'b1;
      write_guard_n <= 1'b0;
    end else begin
      rd_valid <= (st == S_READ) && cyc_done;
      if ((st == S_READ) && cyc_done) begin
        rd_data <= cyc.rdata;
      end
      op_done <= (st == S_DONE);
      chip_select_n <= (st == S_IDLE);
      write_guard_n <= (st != S_IDLE) && op_cbp && allow_write;
    end
  end
  assign req_ready = (st == S_IDLE);
  // the host never drives the open-drain busy line
  assign ready_busy_n_oe_n = 1'b1;
  nrc_strobe u_strobe (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cyc(cyc.phy),
    .io_in(io_in),
    .io_out(io_out),
    .io_oe_n(io_oe_n),
    .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n),
    .command_latch_strobe(command_latch_strobe),
    .address_latch_strobe(address_latch_strobe)
  );
endmodule // nrc_host

/* File: logic/nrc_pkg.sv */
package nrc_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_COPYBACK_READ = 8'h35;
  localparam logic [7:0] CMD_COPYBACK_PROG = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_RANDOM_OUT = 8'h05;
  localparam logic [7:0] CMD_RANDOM_OUT_CONFIRM = 8'hE0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
  localparam logic [7:0] ID_ADDR_DEVICE = 8'h00;
  localparam logic [7:0] ID_ADDR_STANDARD = 8'h20;
  localparam int unsigned ID_DEVICE_BYTES = 5;
  localparam int unsigned ID_STANDARD_BYTES = 4;
  // address layout
  localparam int unsigned COL_W = 12;
  localparam int unsigned ROW_W = 16;
  localparam int unsigned COL_HI_W = 4;
  // host op codes
  localparam logic [2:0] OP_PAGE_READ = 3'h0;
  localparam logic [2:0] OP_RANDOM_OUT = 3'h1;
  localparam logic [2:0] OP_IDENT = 3'h2;
  localparam logic [2:0] OP_PARAM = 3'h3;
  localparam logic [2:0] OP_COPYBACK_READ = 3'h4;
  localparam logic [2:0] OP_FIRST_READ = 3'h5;
  localparam logic [2:0] OP_COPYBACK_PROG = 3'h6;
  localparam logic [2:0] OP_READ_BYTES = 3'h7;
  // strobe timing: each strobe phase in ns and in core cycles (250 MHz)
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned STROBE_LOW_NS = 20;
  localparam int unsigned STROBE_HIGH_NS = 20;
  localparam int unsigned LOW_CYC =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HIGH_CYC =
    (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LOW_CNT = 4'(LOW_CYC);
  localparam logic [3:0] HIGH_CNT = 4'(HIGH_CYC);
  // bus sample delay after read strobe fall, ns and cycles
  localparam int unsigned READ_ACCESS_NS = 16;
  localparam logic [3:0] READ_ACCESS_CNT =
    4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // wait before ready_busy_n is trusted after confirm or the parameter page address
  localparam int unsigned BUSY_SETTLE_NS = 100;
  localparam logic [5:0] BUSY_SETTLE_CNT =
    6'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

/* File: logic/nrc_cycle_if.sv */
`timescale 1ns/10ps
interface nrc_cycle_if;
  logic start;
  logic is_read;
  logic cmd_latch;
  logic addr_latch;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (
    output start,
    output is_read,
    output cmd_latch,
    output addr_latch,
    output wdata,
    input done,
    input rdata
  );
  modport phy (
    input start,
    input is_read,
    input cmd_latch,
    input addr_latch,
    input wdata,
    output done,
    output rdata
  );
endinterface

/* File: logic/nrc_strobe.sv */
`timescale 1ns/10ps
// one bus cycle: write strobe (command/address) or read strobe
module nrc_strobe (
  input wire logic core_clk,
  input wire logic sys_rst,
  nrc_cycle_if.phy cyc,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic command_latch_strobe,
  output logic address_latch_strobe
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10
  } nrc_ph_e;
  nrc_ph_e ph;
  logic [3:0] cnt;
  logic rd;
  logic [7:0] rdata;
  logic done;
  wire low_end = (ph == ST_LOW) && (cnt == nrc_pkg::LOW_CNT - 4'h1);
  wire high_end = (ph == ST_HIGH) && (cnt == nrc_pkg::HIGH_CNT - 4'h1);
  wire sample = (ph == ST_LOW) && rd &&
    (cnt == nrc_pkg::READ_ACCESS_CNT);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph <= ST_IDLE;
      cnt <= 4'h0;
      rd <= 1'b0;
      rdata <= 8'h00;
      done <= 1'b0;
      io_out <= 8'h00;
      io_oe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      command_latch_strobe <= 1'b0;
      address_latch_strobe <= 1'b0;
    end else begin
      done <= high_end;
      if (sample) begin
        rdata <= io_in;
      end
      unique case (ph)
        ST_IDLE: begin
          cnt <= 4'h0;
          if (cyc.start) begin
            ph <= ST_LOW;
            rd <= cyc.is_read;
            io_out <= cyc.wdata;
            io_oe_n <= cyc.is_read;
            // strobes from flops: no decode glitch on the pins
            write_strobe_n <= cyc.is_read;
            read_strobe_n <= !cyc.is_read;
            command_latch_strobe <= cyc.cmd_latch;
            address_latch_strobe <= cyc.addr_latch;
          end
        end
        ST_LOW: begin
          cnt <= low_end ? 4'h0 : cnt + 4'h1;
          if (low_end) begin
            ph <= ST_HIGH;
            // latch happens on this rising write strobe
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
          end
        end
        ST_HIGH: begin
          cnt <= cnt + 4'h1;
          if (high_end) begin
            ph <= ST_IDLE;
            io_oe_n <= 1'b1;
            command_latch_strobe <= 1'b0;
            address_latch_strobe <= 1'b0;
          end
        end
        default: begin
          ph <= ST_IDLE;
          write_strobe_n <= 1'b1;
          read_strobe_n <= 1'b1;
        end
      endcase
    end
  end
  assign cyc.done = done;
  assign cyc.rdata = rdata;
endmodule // nrc_strobe

/* File: verification/nrc_host_props.sv */
`timescale 1ns/10ps
module nrc_host_props (
  input logic core_clk,
  input logic sys_rst,
  input logic req_valid,
  input logic req_ready,
  input logic [2:0] req_op,
  input logic req_allow_write,
  input logic [7:0] io_out,
  input logic io_oe_n,
  input logic chip_select_n,
  input logic write_strobe_n,
  input logic read_strobe_n,
  input logic command_latch_strobe,
  input logic address_latch_strobe,
  input logic write_guard_n,
  input logic ready_busy_n,
  input logic ready_busy_n_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic ws_q;
  logic allow;
  logic [2:0] acnt;
  wire fall = ws_q && !write_strobe_n;
  wire take = req_valid && req_ready;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ws_q <= 1'b1;
      allow <= 1'b0;
      acnt <= 3'h0;
    end else begin
      ws_q <= write_strobe_n;
      if (take)
        allow <= req_allow_write && req_op == nrc_pkg::OP_COPYBACK_PROG;
      if (fall && command_latch_strobe)
        acnt <= 3'h0;
      else if (fall && address_latch_strobe && acnt != 3'h7)
        acnt <= acnt + 3'h1;
    end
  end
  AST_LATCH_EXCL: assert property (
    !(command_latch_strobe && address_latch_strobe))
    else $error("latch strobes overlap");
  AST_STROBE_EXCL: assert property (
    !(!write_strobe_n && !read_strobe_n)) else $error("strobes overlap");
  AST_LATCH_SEL: assert property (
    fall |-> !chip_select_n) else $error("strobe without select");
  AST_WE_DRIVES: assert property (
    !write_strobe_n |-> !io_oe_n) else $error("bus not driven");
  AST_WE_WIDTH: assert property (
    fall |-> !write_strobe_n [*4]) else $error("write strobe short");
  AST_WE_STABLE: assert property (
    !write_strobe_n && !ws_q |-> $stable(io_out))
    else $error("bus moved in strobe");
  AST_COL_HIGH: assert property (
    fall && address_latch_strobe && acnt == 3'h1 |-> io_out[7:4] == 4'h0)
    else $error("column high nibble set");
  AST_GUARD: assert property (
    write_guard_n |-> allow) else $error("guard lifted");
  AST_RE_READY: assert property (
    $fell(read_strobe_n) |-> $past(ready_busy_n, 3))
    else $error("read while busy");
  AST_RB_RELEASED: assert property (
    ready_busy_n_oe_n) else $error("busy line driven by host");
endmodule // nrc_host_props
bind nrc_host nrc_host_props nrc_host_props_i (.core_clk, .sys_rst,
  .req_valid, .req_ready, .req_op, .req_allow_write, .io_out, .io_oe_n,
  .chip_select_n, .write_strobe_n, .read_strobe_n, .command_latch_strobe,
  .address_latch_strobe, .write_guard_n, .ready_busy_n,
  .ready_busy_n_oe_n);

/* File: verification/nrc_flash_model.sv */
`timescale 1ns/10ps
// identification bases are arbitrary
module nrc_flash_model #(
  parameter int LOAD_NS = 400,
  parameter logic [7:0] ID_BASE = 8'hA0,
  parameter logic [7:0] STD_BASE = 8'hB0
) (
  input logic chip_select_n,
  input logic write_strobe_n,
  input logic read_strobe_n,
  input logic command_latch_strobe,
  input logic address_latch_strobe,
  input logic write_guard_n,
  input logic [7:0] io_in,
  output logic [7:0] dev_io = 8'h00,
  output logic rb_dev = 1'b1
);
  logic [7:0] adr [4];
  logic [2:0] acnt = 3'h0;
  logic [1:0] mode = 2'h0;
  logic [11:0] col = 12'h000;
  int progs = 0;
  wire [15:0] row = {adr[3], adr[2]};
  wire [11:0] newcol = {adr[1][3:0], adr[0]};
  wire [7:0] idb = adr[0] == 8'h20 ? STD_BASE : ID_BASE;
  wire [7:0] pgb = row[7:0] ^ row[15:8] ^ col[7:0] ^ {4'h0, col[11:8]};
  wire sel = !chip_select_n;
  always @(posedge write_strobe_n) begin
    if (sel && command_latch_strobe) begin
      acnt <= 3'h0;
      case (io_in)
        8'h30, 8'h35: begin
          mode <= 2'h0;
          col <= newcol;
          rb_dev <= 1'b0;
          rb_dev <= #(LOAD_NS) 1'b1;
        end
        8'hE0: col <= newcol;
        // top bits give 2 for ident, 3 for parameter page
        8'h90, 8'hEC: begin
          mode <= io_in[7:6];
          col <= 12'h000;
        end
        8'h10: if (write_guard_n) progs <= progs + 1;
        default: ;
      endcase
    end else if (sel && address_latch_strobe && acnt < 3'h4) begin
      adr[acnt[1:0]] <= io_in;
      acnt <= acnt + 3'h1;
    end
  end
  always @(negedge read_strobe_n) begin
    if (sel) begin
      case (mode)
        2'h2: dev_io <= #12 idb + col[7:0];
        2'h3: dev_io <= #12 col[7:0] ^ 8'hC5;
        default: dev_io <= #12 pgb;
      endcase
    end
  end
  // read strobe rise inverts the bus byte; chip select rise inverts it again
  always @(posedge read_strobe_n or posedge chip_select_n) begin
    dev_io <= ~dev_io;
    if (sel)
      col <= col + 12'h001;
  end
endmodule // nrc_flash_model

/* File: verification/test_nand_read_command_interface.sv */
`timescale 1ns/10ps
module test_nand_read_command_interface;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [11:0] req_column = 12'h000;
  logic [15:0] req_row = 16'h0000;
  logic req_id_standard = 1'b0;
  logic req_allow_write = 1'b0;
  logic req_ready, rd_valid, op_done, io_oe_n, chip_select_n, rb_dev;
  logic write_strobe_n, read_strobe_n, write_guard_n, ready_busy_n_oe_n;
  logic command_latch_strobe, address_latch_strobe;
  logic [7:0] rd_data, io_out, dev_io;
  wire [7:0] io_in = io_oe_n ? dev_io : io_out;
  wire ready_busy_n = rb_dev & ready_busy_n_oe_n;
  logic [7:0] expq [$];
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h36CBB17B;
  logic [15:0] row;
  logic [11:0] c;
  always #2 core_clk = ~core_clk;
  nrc_host nrc_host_i (.core_clk, .sys_rst, .req_valid, .req_ready,
    .req_op, .req_column, .req_row, .req_id_standard, .req_allow_write,
    .rd_data, .rd_valid, .op_done, .io_out, .io_oe_n, .io_in,
    .chip_select_n, .write_strobe_n, .read_strobe_n, .command_latch_strobe,
    .address_latch_strobe, .write_guard_n, .ready_busy_n,
    .ready_busy_n_oe_n);
  nrc_flash_model nrc_flash_model_i (.chip_select_n, .write_strobe_n,
    .read_strobe_n, .command_latch_strobe, .address_latch_strobe,
    .write_guard_n, .io_in, .dev_io, .rb_dev);
  function automatic logic [7:0] pg(input logic [11:0] k);
    return row[7:0] ^ row[15:8] ^ k[7:0] ^ {4'h0, k[11:8]};
  endfunction
  task automatic chk(input string what, input logic [7:0] e,
      input logic [7:0] g);
    cmp_count++;
    if (e !== g) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic pgq(input logic [11:0] s, input int n);
    for (int i = 0; i < n; i++)
      expq.push_back(pg(s + 12'(i)));
  endtask
  task automatic run(input logic [2:0] op, input logic [11:0] n,
      input logic sd, input logic aw);
    int k;
    k = 0;
    req_op <= op;
    req_column <= n;
    req_row <= row;
    req_id_standard <= sd;
    req_allow_write <= aw;
    req_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 50);
    req_valid <= 1'b0;
    while (op_done !== 1'b1 && k < 20000) begin
      @(posedge core_clk);
      k++;
    end
    chk("op_done", 8'h01, {7'h0, op_done});
    @(posedge core_clk);
    chk("bytes left", 8'h00, 8'(expq.size()));
    $display("op %0d done", op);
  endtask
  always @(posedge core_clk) begin
    if (sys_rst === 1'b0 && rd_valid !== 1'b0 && expq.size() == 0)
      chk("rd_valid", 8'h00, {7'h0, rd_valid});
    else if (sys_rst === 1'b0 && rd_valid === 1'b1)
      chk("rd_data", expq.pop_front(), rd_data);
  end
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    row = 16'($random(seed));
    c = 12'(1 + {$random(seed)} % 8);
    pgq(c, c);
    run(nrc_pkg::OP_FIRST_READ, c, 1'b0, 1'b0);
    repeat (3) begin
      row = 16'($random(seed));
      c = 12'(1 + {$random(seed)} % 8);
      pgq(c, c);
      run(nrc_pkg::OP_PAGE_READ, c, 1'b0, 1'b0);
      pgq(c + c, 3);
      run(nrc_pkg::OP_READ_BYTES, 12'h003, 1'b0, 1'b0);
      c = 12'(1 + {$random(seed)} % 8);
      pgq(c, c);
      run(nrc_pkg::OP_RANDOM_OUT, c, 1'b0, 1'b0);
    end
    pgq(12'h12C, 300);
    run(nrc_pkg::OP_RANDOM_OUT, 12'h12C, 1'b0, 1'b0);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 5 - s; i++)
        expq.push_back((s != 0 ? 8'hB0 : 8'hA0) + 8'(i));
      run(nrc_pkg::OP_IDENT, 12'(5 - s), s[0], 1'b0);
    end
    expq.push_back(8'hB4);
    run(nrc_pkg::OP_READ_BYTES, 12'h001, 1'b0, 1'b0);
    for (int i = 0; i < 259; i++)
      expq.push_back(8'(i < 3 ? i : i - 3) ^ 8'hC5);
    run(nrc_pkg::OP_PARAM, 12'h003, 1'b0, 1'b0);
    run(nrc_pkg::OP_RANDOM_OUT, 12'h100, 1'b0, 1'b0);
    run(nrc_pkg::OP_COPYBACK_READ, 12'h000, 1'b0, 1'b0);
    run(nrc_pkg::OP_COPYBACK_PROG, 12'h000, 1'b0, 1'b0);
    run(nrc_pkg::OP_COPYBACK_PROG, 12'h000, 1'b0, 1'b1);
    chk("programs", 8'h01, 8'(nrc_flash_model_i.progs));
    end_sim();
  end
  initial begin
    #200000;
    n_fail++;
    $display("[ERR] run expected finish seen hang");
    end_sim();
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
endmodule // test_nand_read_command_interface
